//--- hdl/tir_pkg.sv
// Package: register map, field layout and reset values of the threshold interrupt block
package tir_pkg;
    localparam logic [7:0] TIR_ADDR_LOW_HI = 8'h8A;
    localparam logic [7:0] TIR_ADDR_LOW_LO = 8'h8B;
    localparam logic [7:0] TIR_ADDR_HIGH_HI = 8'h8C;
    localparam logic [7:0] TIR_ADDR_HIGH_LO = 8'h8D;
    localparam logic [7:0] TIR_ADDR_STATUS = 8'h8E;
    localparam logic [7:0] TIR_ADDR_MOD = 8'h8F;
    localparam logic [7:0] TIR_ADDR_AMB_IR = 8'h90;

    localparam int TIR_ST_PROX = 3;
    localparam int TIR_ST_ALS = 2;
    localparam int TIR_ST_LOW = 1;
    localparam int TIR_ST_HIGH = 0;

    localparam int TIR_MOD_DELAY_LSB = 5;
    localparam int TIR_MOD_FREQ_LSB = 3;
    localparam int TIR_MOD_DEAD_LSB = 0;

    localparam logic [7:0] TIR_MOD_RESET = 8'h01;
    localparam logic [15:0] TIR_THRESH_RESET = 16'h0000;
    localparam logic [3:0] TIR_STATUS_RESET = 4'h0;
    localparam logic [7:0] TIR_READ_ZERO = 8'h00;

    typedef struct packed {
        logic [15:0] lowThresh;
        logic [15:0] highThresh;
        logic [3:0] status;
        logic [7:0] modTiming;
        logic [7:0] rdData;
    } tir_state_t;
endpackage

//--- hdl/tir_cmp_if.sv
// Interface: threshold comparator link between the register core and the comparator
`timescale 1ns/1ps
`default_nettype none
interface tir_cmp_if;
    logic [15:0] result;
    logic resultDone;
    logic [15:0] lowThresh;
    logic [15:0] highThresh;
    logic belowEvt;
    logic aboveEvt;
    modport core (output result, output resultDone, output lowThresh, output highThresh,
        input belowEvt, input aboveEvt);
    modport cmp (input result, input resultDone, input lowThresh, input highThresh,
        output belowEvt, output aboveEvt);
endinterface
`default_nettype wire

//--- hdl/tir_compare.sv
// Comparator: flags a finished result outside the threshold window
`timescale 1ns/1ps
`default_nettype none
module tir_compare
    import tir_pkg::*;
(
    tir_cmp_if.cmp cmp
);
    // ----------------------------------------
    // Window check
    // ----------------------------------------
    // Strict compares: a result equal to a limit raises nothing
    assign cmp.belowEvt = cmp.resultDone && (cmp.result < cmp.lowThresh);
    assign cmp.aboveEvt = cmp.resultDone && (cmp.result > cmp.highThresh);
endmodule
`default_nettype wire

//--- hdl/tir_core.sv
// Threshold interrupt registers: thresholds, sticky status, modulator timing
// Operation
// - Low threshold, bytes at 8Ah/8Bh, read/write
// - High threshold, bytes at 8Ch/8Dh, read/write
// - Status register 8Eh with four flags
// - Flags stick; writing one clears them
// - Interrupt pin low while any flag set
// - Modulator timing 8Fh: delay, frequency, dead
// - Delay field offsets receiver evaluation, default zero
// - Dead field blanks edges, default one
// - Modulator timing resets to value one
// - Threshold enable gates limit flags
// - Source select: 0 proximity, 1 ambient
// - Ambient ready enable gates its flag
`timescale 1ns/1ps
`default_nettype none
module tir_core
    import tir_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register port
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // Measurement engines
    input wire logic [15:0] proxResult,
    input wire logic proxDone,
    input wire logic [15:0] alsResult,
    input wire logic alsDone,
    input wire logic [7:0] ambIrLevel,
    // Enables held elsewhere
    input wire logic limit_irq_enable,
    input wire logic limit_source_select,
    input wire logic alsReadyIrqEnable,
    input wire logic proxReadyIrqEnable,
    // Modulator controls
    output logic [2:0] modDelayTime,
    output logic [1:0] modProxFreq,
    output logic [2:0] modDeadTime,
    // Open-drain interrupt pad
    output logic intPadOut,
    output logic intPadOe_b
);
    tir_state_t st_r;
    tir_state_t st_nxt;
    tir_cmp_if cmpBus();
    logic [3:0] setEvt;
    logic [3:0] clrReq;

    tir_compare u_cmp (
        .cmp(cmpBus.cmp)
    );

    // ----------------------------------------
    // Comparison source
    // ----------------------------------------
    assign cmpBus.result = limit_source_select ? alsResult : proxResult;
    assign cmpBus.resultDone = limit_source_select ? alsDone : proxDone;
    assign cmpBus.lowThresh = st_r.lowThresh;
    assign cmpBus.highThresh = st_r.highThresh;

    // ----------------------------------------
    // Status events
    // ----------------------------------------
    always_comb begin
        setEvt = 4'h0;
        setEvt[TIR_ST_PROX] = proxDone && proxReadyIrqEnable;
        setEvt[TIR_ST_ALS] = alsDone && alsReadyIrqEnable;
        setEvt[TIR_ST_LOW] = cmpBus.belowEvt && limit_irq_enable;
        setEvt[TIR_ST_HIGH] = cmpBus.aboveEvt && limit_irq_enable;
        clrReq = 4'h0;
        if (regWrEn && regAddr == TIR_ADDR_STATUS) begin
            clrReq = regWrData[3:0];
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Set wins over a clear in the same cycle so no event is lost
        st_nxt.status = (st_r.status & ~clrReq) | setEvt;
        if (regWrEn) begin
            case (regAddr)
                TIR_ADDR_LOW_HI: begin
                    st_nxt.lowThresh[15:8] = regWrData;
                end
                TIR_ADDR_LOW_LO: begin
                    st_nxt.lowThresh[7:0] = regWrData;
                end
                TIR_ADDR_HIGH_HI: begin
                    st_nxt.highThresh[15:8] = regWrData;
                end
                TIR_ADDR_HIGH_LO: begin
                    st_nxt.highThresh[7:0] = regWrData;
                end
                TIR_ADDR_MOD: begin
                    st_nxt.modTiming = regWrData;
                end
                default: begin
                end
            endcase
        end
        if (regRdEn) begin
            case (regAddr)
                TIR_ADDR_LOW_HI: st_nxt.rdData = st_r.lowThresh[15:8];
                TIR_ADDR_LOW_LO: st_nxt.rdData = st_r.lowThresh[7:0];
                TIR_ADDR_HIGH_HI: st_nxt.rdData = st_r.highThresh[15:8];
                TIR_ADDR_HIGH_LO: st_nxt.rdData = st_r.highThresh[7:0];
                TIR_ADDR_STATUS: st_nxt.rdData = {4'h0, st_r.status};
                TIR_ADDR_MOD: st_nxt.rdData = st_r.modTiming;
                // Internal use only; reads pass the raw level through
                TIR_ADDR_AMB_IR: st_nxt.rdData = ambIrLevel;
                default: st_nxt.rdData = TIR_READ_ZERO;
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_r.lowThresh <= TIR_THRESH_RESET;
            st_r.highThresh <= TIR_THRESH_RESET;
            st_r.status <= TIR_STATUS_RESET;
            st_r.modTiming <= TIR_MOD_RESET;
            st_r.rdData <= TIR_READ_ZERO;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign regRdData = st_r.rdData;
    assign modDelayTime = st_r.modTiming[TIR_MOD_DELAY_LSB +: 3];
    assign modProxFreq = st_r.modTiming[TIR_MOD_FREQ_LSB +: 2];
    assign modDeadTime = st_r.modTiming[TIR_MOD_DEAD_LSB +: 3];
    // Pad only ever pulls low; the board pull-up releases it
    assign intPadOut = 1'b0;
    assign intPadOe_b = ~(|st_r.status);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // Write lands one edge later; a same-cycle read still returns the old byte
    low_thresh_wr_a: assert property (regWrEn && regAddr == TIR_ADDR_LOW_LO
        |=> st_r.lowThresh[7:0] == $past(regWrData))
        else $error("low threshold low byte not written");
    low_thresh_rd_a: assert property (regRdEn && regAddr == TIR_ADDR_LOW_HI
        |=> regRdData == $past(st_r.lowThresh[15:8]))
        else $error("low threshold high byte read wrong");
    high_thresh_wr_a: assert property (regWrEn && regAddr == TIR_ADDR_HIGH_LO
        |=> st_r.highThresh[7:0] == $past(regWrData))
        else $error("high threshold low byte not written");
    high_thresh_rd_a: assert property (regRdEn && regAddr == TIR_ADDR_HIGH_HI
        |=> regRdData == $past(st_r.highThresh[15:8]))
        else $error("high threshold high byte read wrong");
    status_read_a: assert property (regRdEn && regAddr == TIR_ADDR_STATUS
        |=> regRdData[7:4] == 4'h0 && regRdData[3:0] == $past(st_r.status))
        else $error("status read wrong");
    flag_sticky_a: assert property (st_r.status[TIR_ST_LOW] && !(regWrEn
        && regAddr == TIR_ADDR_STATUS && regWrData[TIR_ST_LOW]) |=> st_r.status[TIR_ST_LOW])
        else $error("low flag dropped without clear");
    flag_clear_a: assert property (regWrEn && regAddr == TIR_ADDR_STATUS
        && regWrData[TIR_ST_HIGH] && !setEvt[TIR_ST_HIGH] |=> !st_r.status[TIR_ST_HIGH])
        else $error("high flag not cleared");
    // Host writes may only clear; a flag rises from an event alone
    status_no_set_a: assert property (setEvt == 4'h0
        |=> (st_r.status & ~$past(st_r.status)) == 4'h0)
        else $error("flag raised without event");
    pad_level_a: assert property ((st_r.status != 4'h0) == !intPadOe_b && intPadOut == 1'b0)
        else $error("interrupt pad disagrees with status");
    mod_fields_a: assert property (regWrEn && regAddr == TIR_ADDR_MOD
        |=> modDelayTime == $past(regWrData[7:5]) && modProxFreq == $past(regWrData[4:3])
        && modDeadTime == $past(regWrData[2:0]))
        else $error("modulator fields not updated");
    limit_gate_a: assert property (!limit_irq_enable && !st_r.status[TIR_ST_HIGH]
        && !st_r.status[TIR_ST_LOW] |=> !st_r.status[TIR_ST_HIGH] && !st_r.status[TIR_ST_LOW])
        else $error("limit flag set while disabled");
    source_sel_a: assert property (limit_irq_enable && limit_source_select && alsDone
        && alsResult > st_r.highThresh |=> st_r.status[TIR_ST_HIGH])
        else $error("ambient above ceiling missed");
    below_floor_a: assert property (limit_irq_enable && !limit_source_select && proxDone
        && proxResult < st_r.lowThresh |=> st_r.status[TIR_ST_LOW])
        else $error("proximity below floor missed");
    ceiling_prox_a: assert property (limit_irq_enable && !limit_source_select && proxDone
        && proxResult > st_r.highThresh |=> st_r.status[TIR_ST_HIGH])
        else $error("proximity above ceiling missed");
    // Equality is not a crossing; a result at the floor raises nothing
    limit_strict_a: assert property (cmpBus.resultDone && cmpBus.result >= st_r.lowThresh
        && !st_r.status[TIR_ST_LOW] |=> !st_r.status[TIR_ST_LOW])
        else $error("low flag set without crossing");
    als_gate_a: assert property (!alsReadyIrqEnable && !st_r.status[TIR_ST_ALS]
        |=> !st_r.status[TIR_ST_ALS])
        else $error("ambient ready flag set while disabled");
    prox_ready_a: assert property (proxDone && proxReadyIrqEnable
        |=> st_r.status[TIR_ST_PROX])
        else $error("proximity ready flag missed");
    prox_gate_a: assert property (!proxReadyIrqEnable && !st_r.status[TIR_ST_PROX]
        |=> !st_r.status[TIR_ST_PROX])
        else $error("proximity ready flag set while disabled");
    mod_reset_a: assert property ($rose(rst_b) |-> st_r.modTiming == TIR_MOD_RESET)
        else $error("modulator timing reset value wrong");
    reset_state_a: assert property ($rose(rst_b) |-> st_r.status == TIR_STATUS_RESET
        && st_r.lowThresh == TIR_THRESH_RESET && st_r.highThresh == TIR_THRESH_RESET
        && regRdData == TIR_READ_ZERO && intPadOe_b)
        else $error("state after reset wrong");

    pad_pulled_c: cover property (!intPadOe_b ##[1:20] intPadOe_b);
    set_clear_c: cover property (setEvt[TIR_ST_HIGH] && clrReq[TIR_ST_HIGH]);
    als_source_c: cover property (limit_source_select && cmpBus.belowEvt && limit_irq_enable);
    mod_write_c: cover property (regWrEn && regAddr == TIR_ADDR_MOD);
endmodule
`default_nettype wire

//--- bench/tir_host.sv
// Host model: byte accesses to the threshold register block
`timescale 1ns/1ps
`default_nettype none
module tir_host (
    // Clock
    input wire logic mclk,
    // Register port
    output logic regWrEn,
    output logic regRdEn,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    input wire logic [7:0] regRdData
);
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end
    // Idle bus shows the inverse, so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge mclk);
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        regRdEn = 1'b1;
        regAddr = a;
        @(negedge mclk);
        regRdEn = 1'b0;
        regAddr = ~a;
        d = regRdData;
    endtask
endmodule
`default_nettype wire

//--- bench/threshold_interrupt_regs_tb_top.sv
// Testbench: threshold interrupt registers against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module threshold_interrupt_regs_tb_top
    import tir_pkg::*;
;
    logic mclk, rst_b, regWrEn, regRdEn, proxDone, alsDone;
    logic [7:0] regAddr, regWrData, regRdData, ambIrLevel, d;
    logic [15:0] proxResult, alsResult, r, mLow, mHigh;
    logic limit_irq_enable, limit_source_select, alsReadyIrqEnable, proxReadyIrqEnable;
    logic [2:0] modDelayTime, modDeadTime;
    logic [1:0] modProxFreq;
    logic intPadOut, intPadOe_b;
    logic [3:0] mStat;
    logic [7:0] mMod;
    logic [7:0] addrs [6] = '{8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8F, 8'h91};
    int error_cnt, checks, k;
    tir_host host (.mclk(mclk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData));
    tir_core dut (.mclk(mclk), .rst_b(rst_b), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .proxResult(proxResult), .proxDone(proxDone), .alsResult(alsResult),
        .alsDone(alsDone), .ambIrLevel(ambIrLevel), .limit_irq_enable(limit_irq_enable),
        .limit_source_select(limit_source_select), .alsReadyIrqEnable(alsReadyIrqEnable),
        .proxReadyIrqEnable(proxReadyIrqEnable), .modDelayTime(modDelayTime),
        .modProxFreq(modProxFreq), .modDeadTime(modDeadTime), .intPadOut(intPadOut),
        .intPadOe_b(intPadOe_b));
    // ----------------------------------------
    // Checking helpers and model
    // ----------------------------------------
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [7:0] mRead(input logic [7:0] a);
        case (a)
            TIR_ADDR_LOW_HI: mRead = mLow[15:8];
            TIR_ADDR_LOW_LO: mRead = mLow[7:0];
            TIR_ADDR_HIGH_HI: mRead = mHigh[15:8];
            TIR_ADDR_HIGH_LO: mRead = mHigh[7:0];
            TIR_ADDR_STATUS: mRead = {4'h0, mStat};
            TIR_ADDR_MOD: mRead = mMod;
            default: mRead = 8'h00;
        endcase
    endfunction
    task automatic put(input logic [7:0] a, input logic [7:0] v);
        host.wr(a, v);
        case (a)
            TIR_ADDR_LOW_HI: mLow[15:8] = v;
            TIR_ADDR_LOW_LO: mLow[7:0] = v;
            TIR_ADDR_HIGH_HI: mHigh[15:8] = v;
            TIR_ADDR_HIGH_LO: mHigh[7:0] = v;
            TIR_ADDR_STATUS: mStat = mStat & ~v[3:0];
            TIR_ADDR_MOD: mMod = v;
            default: ;
        endcase
    endtask
    task automatic get(input logic [7:0] a);
        host.rd(a, d);
        chk($sformatf("reg %h", a), 16'(mRead(a)), 16'(d));
    endtask
    task automatic pads;
        chk("pad enable", 16'(mStat == 4'h0), 16'(intPadOe_b));
        chk("pad value", 16'h0000, 16'(intPadOut));
        chk("mod fields", 16'(mMod), 16'({modDelayTime, modProxFreq, modDeadTime}));
    endtask
    task automatic doReset(input int n);
        rst_b = 1'b0;
        repeat (n) @(negedge mclk);
        rst_b = 1'b1;
        mLow = 16'h0000;
        mHigh = 16'h0000;
        mStat = 4'h0;
        mMod = 8'h01;
        for (int a = 'h8A; a <= 'h8F; a++) get(8'(a));
        pads();
        $display("test reset done");
    endtask
    task automatic ev(input bit als, input logic [15:0] v, input logic [3:0] c);
        // Optional clear lands on the event edge; the set must win
        if (c != 4'h0) begin
            fork
                host.wr(TIR_ADDR_STATUS, {4'h0, c});
            join_none
        end
        @(negedge mclk);
        {limit_irq_enable, limit_source_select} = 2'($urandom);
        {alsReadyIrqEnable, proxReadyIrqEnable} = 2'($urandom);
        proxDone = !als;
        alsDone = als;
        proxResult = als ? 16'($urandom) : v;
        alsResult = als ? v : 16'($urandom);
        ambIrLevel = 8'($urandom);
        @(negedge mclk);
        proxDone = 1'b0;
        alsDone = 1'b0;
        mStat = mStat & ~c;
        if (!als && proxReadyIrqEnable) mStat[TIR_ST_PROX] = 1'b1;
        if (als && alsReadyIrqEnable) mStat[TIR_ST_ALS] = 1'b1;
        if (limit_irq_enable && limit_source_select == als) begin
            if (v < mLow) mStat[TIR_ST_LOW] = 1'b1;
            if (v > mHigh) mStat[TIR_ST_HIGH] = 1'b1;
        end
        pads();
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog and sequence
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        #3000000;
        error_cnt++;
        results();
    end
    initial begin
        {rst_b, proxDone, alsDone, proxResult, alsResult, ambIrLevel} = '0;
        {limit_irq_enable, limit_source_select, alsReadyIrqEnable, proxReadyIrqEnable} = '0;
        void'($urandom(32'h62B9));
        doReset(20);
        // Unmapped 91h must read zero and ignore writes; 90h is never touched
        repeat (6) begin
            foreach (addrs[j]) put(addrs[j], 8'($urandom));
            foreach (addrs[j]) get(addrs[j]);
            pads();
        end
        $display("test register access done");
        put(TIR_ADDR_LOW_HI, 8'h10);
        put(TIR_ADDR_HIGH_HI, 8'hC0);
        // Boundary results hit equality and one beyond each limit
        for (int i = 0; i < 200; i++) begin
            k = $urandom_range(4, 0);
            r = k == 0 ? mLow : k == 1 ? mLow - 16'h0001 : k == 2 ? mHigh :
                k == 3 ? mHigh + 16'h0001 : 16'($urandom);
            ev(1'($urandom), r, (i % 2 == 1) ? 4'($urandom) : 4'h0);
            if (i % 4 == 3) begin
                get(TIR_ADDR_STATUS);
                put(TIR_ADDR_STATUS, 8'($urandom));
                pads();
            end
        end
        $display("test events done");
        // Odd timing before the mid-run reset so the reset value is seen to return
        put(TIR_ADDR_MOD, 8'($urandom));
        doReset(2);
        put(TIR_ADDR_MOD, 8'h01);
        pads();
        results();
    end
endmodule
`default_nettype wire
